// File: pkg/pmsi_pkg.sv
// Constants shared by the power-management status and interrupt block.
package pmsi_pkg;

   // ------------------------------------------------------------------
   // Register map and widths
   // ------------------------------------------------------------------
   localparam int REG_W = 8;
   localparam logic [7:0] ADDR_CHG_STAT = 8'h01;
   localparam logic [7:0] ADDR_REG_STAT = 8'h02;
   localparam logic [7:0] ADDR_CHG_MASK = 8'h03;
   localparam logic [7:0] ADDR_REG_MASK = 8'h04;
   localparam logic [7:0] ADDR_CHG_ACK = 8'h05;
   localparam logic [7:0] ADDR_REG_ACK = 8'h06;
   localparam logic [7:0] ADDR_CHG_CFG = 8'h07;

   // ------------------------------------------------------------------
   // Reset values and read answers
   // ------------------------------------------------------------------
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [7:0] ACK_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h1b;
   localparam logic [7:0] UNMAPPED_RD = 8'hff;

   // ------------------------------------------------------------------
   // Field layouts
   // ------------------------------------------------------------------
   localparam logic [7:0] CHG_EDGE_BITS = 8'h21;
   localparam logic [7:0] CHG_RESET_BITS = 8'h1e;
   localparam logic [7:0] REG_EDGE_BITS = 8'he0;
   localparam logic [7:0] REG_UNUSED_BITS = 8'h10;
   localparam int CFG_POR_SEL_BIT = 7;
   localparam int REG_BIT_BUTTON = 7;
   localparam int REG_BIT_LID = 6;
   localparam int REG_BIT_UV = 5;
   localparam int REG_BIT_UNUSED = 4;
   localparam int REG_BIT_LINREG_B = 3;
   localparam int REG_BIT_LINREG_A = 2;
   localparam int REG_BIT_MAIN = 1;
   localparam int REG_BIT_CORE = 0;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int POR_LONG_MS = 1000;
   localparam int POR_SHORT_MS = 69;
   localparam int POR_LONG_CYC = POR_LONG_MS * CYC_PER_MS;
   localparam int POR_SHORT_CYC = POR_SHORT_MS * CYC_PER_MS;
   localparam int POR_CNT_W = 25;
   localparam logic [POR_CNT_W-1:0] POR_ONE = 25'h0000001;

endpackage

// File: src/pmsi_status_irq.sv
// Status capture, acknowledge, mask and interrupt logic of the power manager.
`timescale 1ns/1ps
// What this block does
// RULE1 - Thermal-suspend charger bit 5 reports charging paused by on-chip heat.
// RULE2 - Termination-current bit 4 reports charging stopped at termination current.
// RULE3 - Bits 3 to 1 report expiry of precharge, fast-charge or taper timer.
// RULE4 - Bit 0 reports battery temperature outside the permitted range.
// RULE5 - Host writes to charger bits 4 to 1 force charger reset; others ignored.
// RULE6 - Any unmasked charger status bit at 1 drives interrupt output active.
// RULE7 - Regulator bit 7 reports a push-button shutdown request.
// RULE8 - Regulator bit 5 reports supply below the undervoltage threshold.
// RULE9 - Regulator bit 4 has no function and reads zero.
// RULE10 - Bit 3 reports second linear regulator out of regulation, zero if disabled.
// RULE11 - Bit 2 reports first linear regulator out of regulation, zero if disabled.
// RULE12 - Bit 1 reports main converter out of regulation.
// RULE13 - Bit 0 reports core converter fault or low-power control in low-power mode.
// RULE14 - Rising regulator status bit drives interrupt low unless masked.
// RULE15 - Charger mask bits block matching status bits; reset to all ones.
// RULE16 - Regulator mask bits block matching status bits; reset to all ones.
// RULE17 - Set charger acknowledge bit removes its status bit from the interrupt.
// RULE18 - Charger acknowledge bits clear when their status bit clears.
// RULE19 - Set regulator acknowledge bit removes its status bit from the interrupt.
// RULE20 - Regulator acknowledge bits clear with status; both ack registers read-only.
// RULE21 - Config bit 7 selects reset pulse of 1000 ms or 69 ms; resets 1Bh.
// RULE22 - Status read sets acknowledge for every bit read as one.
// RULE23 - Charger bits 5 and 0 edge-set, clear when low and acknowledged.
// RULE24 - Regulator bits 7 to 5 edge-set; bits 3 to 0 follow level.
// RULE25 - Every asynchronous status input is synchronised before edge detection.
module pmsi_status_irq #(
   parameter int POR_LONG_CYCLES = pmsi_pkg::POR_LONG_CYC,
   parameter int POR_SHORT_CYCLES = pmsi_pkg::POR_SHORT_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [pmsi_pkg::REG_W-1:0] reg_wdata,
   input wire logic reg_rd,
   output logic [pmsi_pkg::REG_W-1:0] reg_rdata,
   input wire logic [7:0] chg_cond_in,
   input wire logic power_button_request,
   input wire logic battery_lid_sense,
   input wire logic supply_undervoltage,
   input wire logic linreg_b_power_good,
   input wire logic linreg_a_power_good,
   input wire logic main_conv_power_good,
   input wire logic core_conv_power_good,
   input wire logic linreg_b_enable,
   input wire logic linreg_a_enable,
   input wire logic core_lp_ctrl,
   input wire logic low_power_mode,
   input wire logic reset_pulse_start,
   output logic irq_pin_o,
   output logic irq_pin_oe,
   output logic charger_reset_req,
   output logic [pmsi_pkg::REG_W-1:0] charger_config,
   output logic reset_pulse_duration_n
);
   import pmsi_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] s1_chg;
      logic [7:0] s2_chg;
      logic [7:0] d_chg;
      logic [7:0] s1_reg;
      logic [7:0] s2_reg;
      logic [7:0] d_reg;
      logic [7:0] chg_stat;
      logic [7:0] reg_stat;
      logic [7:0] chg_mask;
      logic [7:0] reg_mask;
      logic [7:0] chg_ack;
      logic [7:0] reg_ack;
      logic [7:0] cfg;
      logic [7:0] rdata;
      logic rst_req;
      logic irq_oe;
      logic [POR_CNT_W-1:0] por_cnt;
      logic por_n;
   } pmsi_state_t;

   pmsi_state_t s_r;
   pmsi_state_t s_nxt;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------

   // Edge bits set on a rise and hold until the input is low and the bit
   // has been acknowledged; a rise in the clearing cycle wins.
   function automatic logic [7:0] pmsi_stat_next(input logic [7:0] lvl,
         input logic [7:0] rise, input logic [7:0] old, input logic [7:0] ack,
         input logic [7:0] edge_m);
      return (lvl & ~edge_m) | (edge_m & (rise | (old & (lvl | ~ack))));
   endfunction

   // An acknowledge lives only as long as its status bit.
   function automatic logic [7:0] pmsi_ack_next(input logic [7:0] stat_n,
         input logic [7:0] ack, input logic [7:0] rd_set);
      return stat_n & (ack | rd_set);
   endfunction

   // ------------------------------------------------------------------
   // Combinational inputs
   // ------------------------------------------------------------------
   logic [7:0] reg_pins;
   logic [7:0] reg_lvl;
   logic [7:0] chg_rise;
   logic [7:0] reg_rise;
   logic rd_chg;
   logic rd_reg;
   logic wr_chg;
   logic [POR_CNT_W-1:0] por_target;

   // The lid pin is active low; it is inverted ahead of the synchroniser.
   assign reg_pins = {power_button_request, ~battery_lid_sense, supply_undervoltage,
      1'b0, linreg_b_power_good, linreg_a_power_good, main_conv_power_good,
      core_conv_power_good};

   // Enables come from register logic on this clock, so they gate after sync.
   always_comb begin
      reg_lvl = s_r.s2_reg;
      reg_lvl[REG_BIT_UNUSED] = 1'b0; // RULE9
      reg_lvl[REG_BIT_LINREG_B] = s_r.s2_reg[REG_BIT_LINREG_B] & linreg_b_enable; // RULE10
      reg_lvl[REG_BIT_LINREG_A] = s_r.s2_reg[REG_BIT_LINREG_A] & linreg_a_enable; // RULE11
      reg_lvl[REG_BIT_CORE] = s_r.s2_reg[REG_BIT_CORE] | (core_lp_ctrl & low_power_mode); // RULE13
   end

   // Edges are taken between the second and third stages only. The regulator
   // edge uses the gated level, but the enable-gated bits 3 and 2 follow level,
   // so enabling a regulator that is out of regulation reports it while it lasts.
   assign chg_rise = s_r.s2_chg & ~s_r.d_chg; // RULE25
   assign reg_rise = reg_lvl & ~s_r.d_reg; // RULE25
   assign rd_chg = reg_rd && (reg_addr == ADDR_CHG_STAT);
   assign rd_reg = reg_rd && (reg_addr == ADDR_REG_STAT);
   assign wr_chg = reg_wr && (reg_addr == ADDR_CHG_STAT);
   assign por_target = s_r.cfg[CFG_POR_SEL_BIT] ? POR_CNT_W'(POR_SHORT_CYCLES - 1)
      : POR_CNT_W'(POR_LONG_CYCLES - 1); // RULE21

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      // Two flip-flop synchronisers plus one delayed copy for edges.
      s_nxt.s1_chg = chg_cond_in; // RULE25
      s_nxt.s2_chg = s_r.s1_chg;
      s_nxt.d_chg = s_r.s2_chg;
      s_nxt.s1_reg = reg_pins;
      s_nxt.s2_reg = s_r.s1_reg;
      s_nxt.d_reg = reg_lvl;
      // Status capture keeps running during a read; the read value is the
      // current register, so nothing arriving now is lost.
      s_nxt.chg_stat = pmsi_stat_next(s_r.s2_chg, chg_rise, s_r.chg_stat, s_r.chg_ack,
         CHG_EDGE_BITS); // RULE1 RULE2 RULE3 RULE4 RULE23
      s_nxt.reg_stat = pmsi_stat_next(reg_lvl, reg_rise, s_r.reg_stat,
         s_r.reg_ack, REG_EDGE_BITS); // RULE7 RULE8 RULE12 RULE24
      s_nxt.chg_ack = pmsi_ack_next(s_nxt.chg_stat, s_r.chg_ack,
         rd_chg ? s_r.chg_stat : ACK_RST); // RULE18 RULE22
      s_nxt.reg_ack = pmsi_ack_next(s_nxt.reg_stat, s_r.reg_ack,
         rd_reg ? s_r.reg_stat : ACK_RST); // RULE20 RULE22
      // Writing zero over a set timeout or termination bit asks the charger
      // to restart; stored bits still follow their inputs.
      s_nxt.rst_req = wr_chg && |(s_r.chg_stat & ~reg_wdata & CHG_RESET_BITS); // RULE5
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CHG_MASK: s_nxt.chg_mask = reg_wdata;
            ADDR_REG_MASK: s_nxt.reg_mask = reg_wdata;
            ADDR_CHG_CFG: s_nxt.cfg = reg_wdata;
            default: s_nxt.cfg = s_r.cfg;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CHG_STAT: s_nxt.rdata = s_r.chg_stat;
            ADDR_REG_STAT: s_nxt.rdata = s_r.reg_stat;
            ADDR_CHG_MASK: s_nxt.rdata = s_r.chg_mask;
            ADDR_REG_MASK: s_nxt.rdata = s_r.reg_mask;
            ADDR_CHG_ACK: s_nxt.rdata = s_r.chg_ack;
            ADDR_REG_ACK: s_nxt.rdata = s_r.reg_ack;
            ADDR_CHG_CFG: s_nxt.rdata = s_r.cfg;
            default: s_nxt.rdata = UNMAPPED_RD;
         endcase
      end
      // Interrupt follows next state so the pin matches the registers.
      s_nxt.irq_oe = |(s_nxt.chg_stat & ~s_nxt.chg_mask & ~s_nxt.chg_ack)
         | |(s_nxt.reg_stat & ~s_nxt.reg_mask & ~s_nxt.reg_ack); // RULE6 RULE14 RULE15 RULE16 RULE17 RULE19
      // Reset pulse timer; the select is read live, so changing it mid pulse
      // shortens or lengthens the pulse in flight.
      if (reset_pulse_start) begin
         s_nxt.por_cnt = '0;
         s_nxt.por_n = 1'b0;
      end else if (!s_r.por_n) begin
         if (s_r.por_cnt >= por_target) begin
            s_nxt.por_n = 1'b1; // RULE21
         end else begin
            s_nxt.por_cnt = s_r.por_cnt + POR_ONE;
         end
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_r <= '0;
         s_r.chg_stat <= STAT_RST;
         s_r.reg_stat <= STAT_RST;
         s_r.chg_mask <= MASK_RST; // RULE15
         s_r.reg_mask <= MASK_RST; // RULE16
         s_r.chg_ack <= ACK_RST;
         s_r.reg_ack <= ACK_RST; // RULE20
         s_r.cfg <= CFG_RST; // RULE21
         s_r.rdata <= UNMAPPED_RD;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // Open-drain interrupt: the pin is only ever pulled low.
   assign irq_pin_o = 1'b0;
   assign irq_pin_oe = s_r.irq_oe;
   assign reg_rdata = s_r.rdata;
   assign charger_reset_req = s_r.rst_req;
   assign charger_config = s_r.cfg;
   assign reset_pulse_duration_n = s_r.por_n;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking pmsi_cb @(posedge clk_sys iff ce);
   endclocking
   default disable iff (reset);

   chg_edge_set_a: assert property ($rose(s_r.s2_chg[0]) |=> s_r.chg_stat[0]) // RULE23
      else $error("charger edge bit not set on rise");
   chg_level_follow_a: assert property (s_r.chg_stat[4:1] == $past(s_r.s2_chg[4:1])) // RULE2
      else $error("charger level bits do not follow input");
   edge_clear_cause_a: assert property ($fell(s_r.chg_stat[5])
         |-> $past(s_r.chg_ack[5]) && !$past(s_r.s2_chg[5])) // RULE23
      else $error("charger edge bit cleared without ack");
   ack_needs_stat_a: assert property (((s_r.chg_ack & ~s_r.chg_stat) == 8'h00)
         && ((s_r.reg_ack & ~s_r.reg_stat) == 8'h00)) // RULE18
      else $error("ack set while status clear");
   read_sets_ack_a: assert property (rd_reg
         |=> ((~s_r.reg_ack & s_r.reg_stat & $past(s_r.reg_stat)) == 8'h00)) // RULE22
      else $error("read did not acknowledge set bits");
   unused_bit_zero_a: assert property (!s_r.reg_stat[REG_BIT_UNUSED]) // RULE9
      else $error("unused regulator bit set");
   linreg_off_zero_a: assert property (!linreg_a_enable |=> ##1 !s_r.reg_stat[REG_BIT_LINREG_A]
         || $past(linreg_a_enable)) // RULE11
      else $error("disabled regulator reports fault");
   masked_quiet_a: assert property ((&s_r.chg_mask && &s_r.reg_mask) |-> !irq_pin_oe) // RULE15
      else $error("interrupt active with all masked");
   unmapped_read_a: assert property (reg_rd && (reg_addr > ADDR_CHG_CFG)
         |=> reg_rdata == UNMAPPED_RD)
      else $error("unmapped read not all ones");
   mask_reset_a: assert property ($past(reset) |-> (s_r.chg_mask == MASK_RST)
         && (s_r.reg_mask == MASK_RST) && (s_r.cfg == CFG_RST)) // RULE16
      else $error("mask or config reset value wrong");
   chg_reset_req_a: assert property (wr_chg && |(s_r.chg_stat & ~reg_wdata & CHG_RESET_BITS)
         |=> charger_reset_req) // RULE5
      else $error("charger reset request missing");

   // ------------------------------------------------------------------
   // Interrupt path checks
   // ------------------------------------------------------------------

   // The open-drain data level never changes; only the enable moves.
   irq_data_low_a: assert property (!irq_pin_o) // RULE6
      else $error("interrupt data level not low");

   // An unmasked, unacknowledged charger bit must hold the pin active.
   chg_irq_on_a: assert property (|(s_r.chg_stat & ~s_r.chg_mask & ~s_r.chg_ack)
         |-> irq_pin_oe) // RULE6 RULE15
      else $error("charger condition not on interrupt");

   // An unmasked, unacknowledged regulator bit must hold the pin active.
   reg_irq_on_a: assert property (|(s_r.reg_stat & ~s_r.reg_mask & ~s_r.reg_ack)
         |-> irq_pin_oe) // RULE14 RULE16
      else $error("regulator condition not on interrupt");

   // The pin may only be active while some condition is still pending.
   irq_has_cause_a: assert property (irq_pin_oe
         |-> (|(s_r.chg_stat & ~s_r.chg_mask & ~s_r.chg_ack))
         || (|(s_r.reg_stat & ~s_r.reg_mask & ~s_r.reg_ack))) // RULE17 RULE19
      else $error("interrupt active without cause");

   // Once every set bit is acknowledged the pin must be released.
   all_acked_quiet_a: assert property ((s_r.chg_ack == s_r.chg_stat)
         && (s_r.reg_ack == s_r.reg_stat) |-> !irq_pin_oe) // RULE17 RULE19
      else $error("interrupt active after full acknowledge");

   // ------------------------------------------------------------------
   // Acknowledge checks
   // ------------------------------------------------------------------

   // A level bit that drops must take its acknowledge with it.
   chg_ack_drop_a: assert property ($fell(s_r.chg_stat[4]) |-> !s_r.chg_ack[4]) // RULE18
      else $error("charger ack outlived status");

   // Same for a regulator bit.
   reg_ack_drop_a: assert property ($fell(s_r.reg_stat[REG_BIT_LINREG_A])
         |-> !s_r.reg_ack[REG_BIT_LINREG_A]) // RULE20
      else $error("regulator ack outlived status");

   // A charger status read acknowledges every bit that it returned as one.
   chg_read_ack_a: assert property (rd_chg
         |=> ((~s_r.chg_ack & s_r.chg_stat & $past(s_r.chg_stat)) == 8'h00)) // RULE22
      else $error("charger read did not acknowledge");

   // The value returned is the register as it stood at the strobe.
   chg_read_data_a: assert property (rd_chg |=> reg_rdata == $past(s_r.chg_stat)) // RULE22
      else $error("charger read data wrong");

   // ------------------------------------------------------------------
   // Status capture checks
   // ------------------------------------------------------------------

   // Thermal suspend is captured on its rising edge.
   thermal_edge_a: assert property ($rose(s_r.s2_chg[5]) |=> s_r.chg_stat[5]) // RULE1
      else $error("thermal bit not set on rise");

   // The timeout bits simply follow their synchronised inputs.
   timeout_follow_a: assert property (!$past(reset)
         |-> s_r.chg_stat[3:1] == $past(s_r.s2_chg[3:1])) // RULE3
      else $error("timeout bits do not follow input");

   // The push-button request is captured on its rising edge.
   button_edge_a: assert property ($rose(reg_lvl[REG_BIT_BUTTON])
         |=> s_r.reg_stat[REG_BIT_BUTTON]) // RULE7
      else $error("button bit not set on rise");

   // Power-good bits follow their gated level one cycle later; the first
   // cycle after reset is skipped because the level was not yet sampled.
   reg_level_follow_a: assert property (!$past(reset)
         |-> s_r.reg_stat[3:0] == $past(reg_lvl[3:0])) // RULE10 RULE11 RULE12 RULE13
      else $error("regulator level bits do not follow");

   // Undervoltage only clears when low and already acknowledged.
   uv_edge_clear_a: assert property (!$past(reset) && $fell(s_r.reg_stat[REG_BIT_UV])
         |-> $past(s_r.reg_ack[REG_BIT_UV]) && !$past(reg_lvl[REG_BIT_UV])) // RULE8
      else $error("undervoltage bit cleared without ack");

   // ------------------------------------------------------------------
   // Register and pulse checks
   // ------------------------------------------------------------------

   // A configuration write lands whole on the next cycle.
   cfg_write_a: assert property (reg_wr && (reg_addr == ADDR_CHG_CFG)
         |=> charger_config == $past(reg_wdata)) // RULE21
      else $error("config write lost");

   // A regulator mask write lands whole on the next cycle.
   reg_mask_write_a: assert property (reg_wr && (reg_addr == ADDR_REG_MASK)
         |=> s_r.reg_mask == $past(reg_wdata)) // RULE16
      else $error("regulator mask write lost");

   // The charger is only told to restart by a status register write.
   reset_req_cause_a: assert property (charger_reset_req |-> $past(wr_chg)) // RULE5
      else $error("charger reset request without write");

   // A start request always drops the reset output on the next cycle.
   pulse_start_a: assert property (reset_pulse_start |=> !reset_pulse_duration_n) // RULE21
      else $error("reset pulse did not start");

endmodule // pmsi_status_irq

// File: test/pmsi_host_model.sv
// Host model that reaches the status block through its register strobe port.
`timescale 1ns/1ps
module pmsi_host_model (
   input wire logic clk_sys,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd
);
   // ------------------------------------------------------------------
   // Bus cycles
   // ------------------------------------------------------------------
   // Idle strobes low; address and data start scrambled, never zero.
   initial begin
      reg_addr = 8'ha5;
      reg_wr = 1'h0;
      reg_wdata = 8'h5a;
      reg_rd = 1'h0;
   end

   // One write; address and data are inverted after it so stale values never look live.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // One read; the answer is taken one edge after the strobe was sampled.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask
endmodule // pmsi_host_model

// File: test/tb.sv
// Self-checking bench of the status and interrupt block.
`timescale 1ns/1ps
module tb;
   import pmsi_pkg::*;
   localparam int LONG = 40;
   localparam int SHORT = 20;
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   logic ce = 1'h1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, charger_config, d, v;
   logic [7:0] chg_cond_in = 8'h00;
   logic reg_wr, reg_rd, irq_pin_o, irq_pin_oe, charger_reset_req, reset_pulse_duration_n;
   logic reset_pulse_start = 1'h0;
   // Order: button, lid, undervoltage, lin b, lin a, main, core, en b, en a, lp ctrl, lp mode.
   logic [10:0] rg = 11'h204;
   logic [31:0] seed = 32'ha4a1;
   int n_errors = 0, n_tests = 0, n_req = 0, n;

   always #20 clk_sys = ~clk_sys;
   // A reset request must be a single-cycle pulse, so every high cycle is counted.
   always @(posedge clk_sys) if (charger_reset_req === 1'h1) n_req++;

   pmsi_status_irq #(.POR_LONG_CYCLES(LONG), .POR_SHORT_CYCLES(SHORT)) dut (
      .clk_sys, .reset, .ce, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
      .chg_cond_in, .power_button_request(rg[10]), .battery_lid_sense(rg[9]),
      .supply_undervoltage(rg[8]), .linreg_b_power_good(rg[7]),
      .linreg_a_power_good(rg[6]), .main_conv_power_good(rg[5]),
      .core_conv_power_good(rg[4]), .linreg_b_enable(rg[3]), .linreg_a_enable(rg[2]),
      .core_lp_ctrl(rg[1]), .low_power_mode(rg[0]), .reset_pulse_start, .irq_pin_o,
      .irq_pin_oe, .charger_reset_req, .charger_config, .reset_pulse_duration_n);
   pmsi_host_model host (.clk_sys, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] rst_val(input logic [7:0] a);
      case (a)
         ADDR_CHG_MASK, ADDR_REG_MASK: return 8'hff;
         ADDR_CHG_CFG: return 8'h1b;
         8'h00, 8'h08: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction
   task automatic end_of_test;
      if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   // Counting edges until release; a stuck output would otherwise hang the run.
   task automatic pulse_len(input int t);
      int c;
      c = 0;
      while (reset_pulse_duration_n !== 1'h1) begin
         @(posedge clk_sys);
         c++;
         if (c > 200) begin
            n_errors++;
            end_of_test;
         end
      end
      chk({7'h00, c >= t - 2 && c <= t + 2}, 8'h01);
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      tick(10);
      reset <= 1'h0;
      pulse_len(LONG + 1);
      for (int a = 0; a < 9; a++) begin
         host.rd(a[7:0], d);
         chk(d, rst_val(a[7:0]));
      end
      seed = lfsr(seed);
      host.wr(ADDR_REG_ACK, seed[7:0]);
      host.wr(ADDR_REG_STAT, seed[15:8]);
      host.rd(ADDR_REG_ACK, d);
      chk(d, 8'h00);
      // Random level conditions under a random mask, then a forced charger reset.
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         v = (seed[7:0] & 8'hde) | 8'h10;
         host.wr(ADDR_CHG_MASK, seed[15:8]);
         chg_cond_in <= v;
         tick(4);
         chk({7'h00, irq_pin_oe}, {7'h00, |(v & ~seed[15:8])});
         host.rd(ADDR_CHG_MASK, d);
         chk(d, seed[15:8]);
         host.rd(ADDR_CHG_STAT, d);
         chk(d, v);
         chk({7'h00, irq_pin_oe}, 8'h00);
         host.rd(ADDR_CHG_ACK, d);
         chk(d, v);
         n = n_req;
         host.wr(ADDR_CHG_STAT, 8'hef);
         host.wr(ADDR_CHG_STAT, 8'hff);
         tick(3);
         chk(8'(n_req - n), 8'h01);
         host.rd(ADDR_CHG_STAT, d);
         chk(d, v);
         chg_cond_in <= 8'h00;
         tick(4);
         host.rd(ADDR_CHG_ACK, d);
         chk(d, 8'h00);
      end
      // Edge-set charger bits must outlive their short input pulse.
      host.wr(ADDR_CHG_MASK, 8'h00);
      chg_cond_in <= 8'h21;
      tick(4);
      chg_cond_in <= 8'h00;
      tick(4);
      chk({7'h00, irq_pin_oe}, 8'h01);
      host.rd(ADDR_CHG_STAT, d);
      chk(d, 8'h21);
      tick(2);
      host.rd(ADDR_CHG_STAT, d);
      chk(d, 8'h00);
      // Regulator faults; lin b stays out while disabled.
      host.wr(ADDR_REG_MASK, 8'h00);
      rg <= 11'h5e7;
      tick(4);
      chk({7'h00, irq_pin_oe}, 8'h01);
      host.rd(ADDR_REG_STAT, d);
      chk(d, 8'he7);
      chk({7'h00, irq_pin_oe}, 8'h00);
      host.rd(ADDR_REG_ACK, d);
      chk(d, 8'he7);
      rg <= 11'h5ef;
      tick(4);
      chk({7'h00, irq_pin_oe}, 8'h01);
      rg <= 11'h206;
      tick(4);
      host.rd(ADDR_REG_STAT, d);
      chk(d, 8'h00);
      host.rd(ADDR_REG_ACK, d);
      chk(d, 8'h00);
      chk({7'h00, irq_pin_o}, 8'h00);
      // Short reset pulse selection.
      host.wr(ADDR_CHG_CFG, 8'h9b);
      host.rd(ADDR_CHG_CFG, d);
      chk(d, 8'h9b);
      chk(charger_config, 8'h9b);
      reset_pulse_start <= 1'h1;
      tick(1);
      reset_pulse_start <= 1'h0;
      tick(1);
      pulse_len(SHORT + 1);
      // Clock enable low freezes capture; nothing may reach the pin until it returns.
      ce <= 1'h0;
      chg_cond_in <= 8'h01;
      tick(6);
      chk({7'h00, irq_pin_oe}, 8'h00);
      ce <= 1'h1;
      tick(4);
      chk({7'h00, irq_pin_oe}, 8'h01);
      end_of_test;
   end
endmodule // tb
